// ---- dscg_pkg.sv ----
// Constants for the deep-sleep clock gate bank 1 block.
// Assumes a single 50 MHz system clock and an AHB-Lite register bus.
`default_nettype none

package dscg_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] DSCG_ADDR_GATE   = 12'h124;
	localparam logic [11:0] DSCG_ADDR_FAULT  = 12'h180;
	localparam logic [11:0] DSCG_ADDR_MASK   = 12'h184;
	localparam logic [11:0] DSCG_ADDR_ACTIVE = 12'h188;
	localparam int          DSCG_ADDR_W      = 12;

	// ==========================================================
	// Field layout of the gate register
	localparam int DSCG_BIT_ASYNC0 = 0;
	localparam int DSCG_BIT_ASYNC1 = 1;
	localparam int DSCG_BIT_SYNC0  = 4;
	localparam int DSCG_BIT_SYNC1  = 5;
	localparam int DSCG_BIT_TWI0   = 12;
	localparam int DSCG_BIT_TWI1   = 14;
	localparam int DSCG_BIT_CNT0   = 16;
	localparam int DSCG_BIT_CNT1   = 17;
	localparam int DSCG_BIT_CNT2   = 18;
	localparam int DSCG_BIT_CNT3   = 19;
	localparam int DSCG_BIT_CMP0   = 24;
	localparam int DSCG_BIT_CMP1   = 25;

	// Writable bits; everything else is reserved and reads zero
	localparam logic [31:0] DSCG_RW_MASK    = 32'h030F_5033;
	localparam logic [31:0] DSCG_RESET_VAL  = 32'h0000_0000;
	localparam logic [31:0] DSCG_ZERO_WORD  = 32'h0000_0000;

	// ==========================================================
	// Peripheral unit numbering on the access-check port
	localparam int          DSCG_UNITS  = 12;
	localparam logic [3:0]  DSCG_UNIT_W = 4'h4;

	localparam logic [1:0]  DSCG_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  DSCG_HRESP_OKAY    = 2'h0;

	// Bit position in the gate register of unit n
	function automatic logic [4:0] dscg_unit_bit(input logic [3:0] unit);
		logic [4:0] pos;
		pos = 5'h00;
		case (unit)
			4'h0: pos = 5'(DSCG_BIT_ASYNC0);
			4'h1: pos = 5'(DSCG_BIT_ASYNC1);
			4'h2: pos = 5'(DSCG_BIT_SYNC0);
			4'h3: pos = 5'(DSCG_BIT_SYNC1);
			4'h4: pos = 5'(DSCG_BIT_TWI0);
			4'h5: pos = 5'(DSCG_BIT_TWI1);
			4'h6: pos = 5'(DSCG_BIT_CNT0);
			4'h7: pos = 5'(DSCG_BIT_CNT1);
			4'h8: pos = 5'(DSCG_BIT_CNT2);
			4'h9: pos = 5'(DSCG_BIT_CNT3);
			4'hA: pos = 5'(DSCG_BIT_CMP0);
			4'hB: pos = 5'(DSCG_BIT_CMP1);
			default: pos = 5'h00;
		endcase
		return pos;
	endfunction

endpackage

`default_nettype wire

// ---- dscg_gate_bank.sv ----
// Deep-sleep clock gate bank 1: gate register, mode selection of the active
// gate set, per-unit clock enables, access fault check and fault interrupt.
// Assumes run and light-sleep gate sets and the power mode come from logic
// on the same clock; registers are reached over AHB-Lite.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module dscg_gate_bank
	import dscg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [1:0]       hresp,
	output logic [31:0]      hrdata,
	// Power mode and companion gate sets
	input  wire logic        sleep_mode,
	input  wire logic        deep_sleep_mode,
	input  wire logic        auto_clock_gating_select,
	input  wire logic [31:0] run_clock_gate_1,
	input  wire logic [31:0] light_sleep_clock_gate_1,
	// Peripheral access check
	input  wire logic        unit_access,
	input  wire logic [3:0]  unit_select,
	output logic             unit_grant,
	output logic             unit_fault,
	// Per-unit clock enables
	output logic             async_serial_port0_gate,
	output logic             async_serial_port1_gate,
	output logic             sync_serial_port0_gate,
	output logic             sync_serial_port1_gate,
	output logic             two_wire_port0_gate,
	output logic             two_wire_port1_gate,
	output logic             gp_counter0_gate,
	output logic             gp_counter1_gate,
	output logic             gp_counter2_gate,
	output logic             gp_counter3_gate,
	output logic             comparator_unit0_gate,
	output logic             comparator_unit1_gate,
	output logic             irq
);

	// ==========================================================
	// Bus address phase capture
	logic                    ap_take;
	logic                    dp_write_q;
	logic [DSCG_ADDR_W-1:0]  dp_addr_q;
	logic                    rd_take;
	logic [DSCG_ADDR_W-1:0]  ap_addr;

	assign ap_take = hsel & hready & (htrans == DSCG_HTRANS_NONSEQ | htrans[1]);
	assign ap_addr = haddr[DSCG_ADDR_W-1:0];
	assign rd_take = ap_take & ~hwrite;

	always_ff @(posedge clk) begin
		if (srst) begin
			dp_write_q <= 1'b0;
			dp_addr_q  <= '0;
		end else begin
			dp_write_q <= ap_take & hwrite;
			if (ap_take) begin
				dp_addr_q <= ap_addr;
			end
		end
	end

	// Zero wait states; errors are never signalled on this bus
	assign hreadyout = 1'b1;
	assign hresp     = DSCG_HRESP_OKAY;

	// ==========================================================
	// Gate register
	logic [31:0] gate_q;
	logic [31:0] gate_d;
	logic        gate_wr;

	assign gate_wr = dp_write_q & (dp_addr_q == DSCG_ADDR_GATE);

	always_comb begin
		gate_d = gate_q;
		if (gate_wr) begin
			gate_d = hwdata & DSCG_RW_MASK;
		end
	end

	// Only a bus write moves a gate bit; nothing else sets one
	always_ff @(posedge clk) begin
		if (srst) begin
			gate_q <= DSCG_RESET_VAL;
		end else begin
			gate_q <= gate_d;
		end
	end

	// ==========================================================
	// Interrupt mask register
	logic [31:0] mask_q;
	logic [31:0] mask_d;

	always_comb begin
		mask_d = mask_q;
		if (dp_write_q & (dp_addr_q == DSCG_ADDR_MASK)) begin
			mask_d = hwdata & DSCG_RW_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mask_q <= DSCG_RESET_VAL;
		end else begin
			mask_q <= mask_d;
		end
	end

	// ==========================================================
	// Active gate set by power mode
	logic [31:0] active_d;
	logic [31:0] active_q;

	// Sleep sets only apply with auto gating; otherwise run set stays
	always_comb begin
		active_d = run_clock_gate_1;
		if (auto_clock_gating_select) begin
			if (deep_sleep_mode) begin
				active_d = gate_q;
			end else if (sleep_mode) begin
				active_d = light_sleep_clock_gate_1;
			end
		end
		active_d = active_d & DSCG_RW_MASK;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			active_q <= DSCG_RESET_VAL;
		end else begin
			active_q <= active_d;
		end
	end

	// ==========================================================
	// Per-unit clock enables
	assign async_serial_port0_gate = active_q[DSCG_BIT_ASYNC0];
	assign async_serial_port1_gate = active_q[DSCG_BIT_ASYNC1];
	assign sync_serial_port0_gate  = active_q[DSCG_BIT_SYNC0];
	assign sync_serial_port1_gate  = active_q[DSCG_BIT_SYNC1];
	assign two_wire_port0_gate     = active_q[DSCG_BIT_TWI0];
	assign two_wire_port1_gate     = active_q[DSCG_BIT_TWI1];
	assign gp_counter0_gate        = active_q[DSCG_BIT_CNT0];
	assign gp_counter1_gate        = active_q[DSCG_BIT_CNT1];
	assign gp_counter2_gate        = active_q[DSCG_BIT_CNT2];
	assign gp_counter3_gate        = active_q[DSCG_BIT_CNT3];
	assign comparator_unit0_gate   = active_q[DSCG_BIT_CMP0];
	assign comparator_unit1_gate   = active_q[DSCG_BIT_CMP1];

	// ==========================================================
	// Access check against the enables the units see
	logic        unit_known;
	logic        unit_clocked;
	logic [4:0]  unit_pos;
	logic        grant_q;
	logic        fault_q;
	logic [31:0] fault_set;

	assign unit_known   = unit_select < DSCG_UNIT_W'(DSCG_UNITS);
	assign unit_pos     = dscg_unit_bit(unit_select);
	assign unit_clocked = unit_known & active_q[unit_pos];

	always_comb begin
		fault_set = DSCG_ZERO_WORD;
		if (unit_access & unit_known & ~unit_clocked) begin
			fault_set[unit_pos] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			grant_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			grant_q <= unit_access & unit_clocked;
			fault_q <= unit_access & ~unit_clocked;
		end
	end

	assign unit_grant = grant_q;
	assign unit_fault = fault_q;

	// ==========================================================
	// Fault status, cleared by reading it
	logic [31:0] status_q;
	logic        status_rd;

	assign status_rd = rd_take & (ap_addr == DSCG_ADDR_FAULT);

	// A fault in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (srst) begin
			status_q <= DSCG_RESET_VAL;
		end else if (status_rd) begin
			status_q <= fault_set;
		end else begin
			status_q <= status_q | fault_set;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((status_q | fault_set) & mask_d & ~({32{status_rd}} & status_q));
		end
	end

	// ==========================================================
	// Read data, captured in the address phase
	logic [31:0] rdata_d;

	// The _d values forward a write still in its data phase
	always_comb begin
		rdata_d = DSCG_ZERO_WORD;
		unique case (ap_addr)
			DSCG_ADDR_GATE:   rdata_d = gate_d;
			DSCG_ADDR_FAULT:  rdata_d = status_q;
			DSCG_ADDR_MASK:   rdata_d = mask_d;
			DSCG_ADDR_ACTIVE: rdata_d = active_q;
			default:          rdata_d = DSCG_ZERO_WORD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= DSCG_ZERO_WORD;
		end else if (rd_take) begin
			hrdata <= rdata_d;
		end
	end

	// Sub-word sizes are treated as whole-word accesses
	logic unused_ok;
	assign unused_ok = ^{hsize, haddr[31:DSCG_ADDR_W]};

endmodule

`default_nettype wire

// ---- dscg_gate_bank_chk.sv ----
// Port checker for dscg_gate_bank.
// Bound from the bench top file; hready is tied to hreadyout there.
`timescale 1ns/1ns
`default_nettype none
module dscg_gate_bank_chk
	import dscg_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        sleep_mode,
	input wire logic        deep_sleep_mode,
	input wire logic        auto_clock_gating_select,
	input wire logic [31:0] run_clock_gate_1,
	input wire logic [31:0] light_sleep_clock_gate_1,
	input wire logic        unit_access,
	input wire logic [3:0]  unit_select,
	input wire logic        unit_grant,
	input wire logic        unit_fault,
	input wire logic        async_serial_port0_gate,
	input wire logic        async_serial_port1_gate,
	input wire logic        sync_serial_port0_gate,
	input wire logic        sync_serial_port1_gate,
	input wire logic        two_wire_port0_gate,
	input wire logic        two_wire_port1_gate,
	input wire logic        gp_counter0_gate,
	input wire logic        gp_counter1_gate,
	input wire logic        gp_counter2_gate,
	input wire logic        gp_counter3_gate,
	input wire logic        comparator_unit0_gate,
	input wire logic        comparator_unit1_gate
);
	// ==========================================================
	// Gates rebuilt into the register layout
	logic [11:0] gv;
	logic [31:0] gw;
	logic        dsel;
	logic        wtake;
	logic        on;
	assign gv = {comparator_unit1_gate, comparator_unit0_gate, gp_counter3_gate, gp_counter2_gate, gp_counter1_gate,
		gp_counter0_gate, two_wire_port1_gate, two_wire_port0_gate, sync_serial_port1_gate,
		sync_serial_port0_gate, async_serial_port1_gate, async_serial_port0_gate};
	assign gw = {6'h0, gv[11:10], 4'h0, gv[9:6], 1'h0, gv[5], 1'h0, gv[4], 6'h0, gv[3:2], 2'h0, gv[1:0]};
	assign dsel = deep_sleep_mode & auto_clock_gating_select;
	assign wtake = hsel & hready & htrans[1] & hwrite & (haddr[11:0] == DSCG_ADDR_GATE);
	// Guard keeps an unknown index from reading past the gate vector
	assign on = (unit_select < 4'hC) && gv[unit_select];
	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_reset_gates_off: assert property ($fell(srst) |-> gw == 32'h0) else $error("gates on after reset");
	a_grant_clocked: assert property (unit_access && on |=> unit_grant && !unit_fault) else $error("no grant");
	a_fault_gated: assert property (unit_access && !on |=> unit_fault && !unit_grant) else $error("no fault");
	a_fault_unknown: assert property (unit_access && unit_select > 4'hB |=> unit_fault) else $error("bad index");
	a_answer_quiet: assert property (!unit_access |=> !unit_grant && !unit_fault) else $error("stray answer");
	a_run_set_used: assert property (!auto_clock_gating_select |=>
		gw == ($past(run_clock_gate_1) & DSCG_RW_MASK)) else $error("run set not applied");
	a_sleep_set_used: assert property (auto_clock_gating_select && sleep_mode && !deep_sleep_mode |=>
		gw == ($past(light_sleep_clock_gate_1) & DSCG_RW_MASK)) else $error("sleep set not applied");
	a_deep_gates_hold: assert property (dsel && $past(dsel) && !$past(wtake, 2) |=> $stable(gw))
		else $error("gates changed without a write");
	c_grant: cover property (unit_access ##1 unit_grant);
	c_fault: cover property (unit_access ##1 unit_fault);
	c_deep_write: cover property (dsel && wtake);
endmodule
`default_nettype wire

// ---- dscg_gate_bank_test.sv ----
// Self-checking bench for dscg_gate_bank.
// Drives the AHB-Lite bus, power mode inputs and access checks itself.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; $display("ERROR %0t mismatch", $time); end end
module dscg_gate_bank_test
	import dscg_pkg::*;
;
	logic        clk, srst, hsel, hwrite, hready, hreadyout, sleep_mode, deep_sleep_mode;
	logic        auto_clock_gating_select, unit_access, unit_grant, unit_fault, irq;
	logic [1:0]  htrans, hresp;
	logic [2:0]  hsize;
	logic [3:0]  unit_select;
	logic [31:0] haddr, hwdata, hrdata, run_clock_gate_1, light_sleep_clock_gate_1;
	logic        async_serial_port0_gate, async_serial_port1_gate, sync_serial_port0_gate, sync_serial_port1_gate;
	logic        two_wire_port0_gate, two_wire_port1_gate, gp_counter0_gate, gp_counter1_gate;
	logic        gp_counter2_gate, gp_counter3_gate, comparator_unit0_gate, comparator_unit1_gate;
	logic [11:0] gv;
	int          n_errors, tests_run;
	int          cyc = 0;
	int          pos [12] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};
	assign hready = hreadyout;
	assign gv = {comparator_unit1_gate, comparator_unit0_gate, gp_counter3_gate, gp_counter2_gate, gp_counter1_gate,
		gp_counter0_gate, two_wire_port1_gate, two_wire_port0_gate, sync_serial_port1_gate,
		sync_serial_port0_gate, async_serial_port1_gate, async_serial_port0_gate};
	dscg_gate_bank i_dscg_gate_bank (.*);
	always #10 clk = ~clk;
	// ==========================================================
	// Bus, access and verdict tasks
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= DSCG_HTRANS_NONSEQ;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
		q = hrdata;
		hsel <= 1'h0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'h1, d, q);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(a, 1'h0, 32'h0, q);
		`CHK(q, e)
	endtask
	task automatic ua(input logic [3:0] n, input logic g);
		@(posedge clk);
		unit_access <= 1'h1;
		unit_select <= n;
		@(posedge clk);
		unit_access <= 1'h0;
		#1;
		`CHK({unit_grant, unit_fault}, {g, !g})
	endtask
	// Gates and irq are registered behind their source
	task automatic st;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic stop_test;
		if (n_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			stop_test();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		{clk, hsel, hwrite, sleep_mode, deep_sleep_mode, auto_clock_gating_select, unit_access} = '0;
		{htrans, unit_select, haddr, hwdata, run_clock_gate_1, light_sleep_clock_gate_1} = '0;
		{n_errors, tests_run} = '0;
		hsize = 3'h2;
		srst = 1'h1;
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		rdc(32'(DSCG_ADDR_GATE), 32'h0);
		auto_clock_gating_select <= 1'h1;
		deep_sleep_mode <= 1'h1;
		st();
		`CHK(gv, 12'h000)
		for (int n = 0; n < 12; n++) begin
			wr(32'(DSCG_ADDR_GATE), 32'h1 << pos[n]);
			rdc(32'(DSCG_ADDR_GATE), 32'h1 << pos[n]);
			st();
			`CHK(gv, 12'h1 << n)
			ua(4'(n), 1'h1);
			ua(4'((n + 1) % 12), 1'h0);
		end
		`CHK(irq, 1'h0)
		wr(32'(DSCG_ADDR_MASK), 32'hFFFF_FFFF);
		st();
		`CHK(irq, 1'h1)
		rdc(32'(DSCG_ADDR_FAULT), DSCG_RW_MASK);
		st();
		`CHK(irq, 1'h0)
		ua(4'hF, 1'h0);
		st();
		`CHK(irq, 1'h0)
		wr(32'(DSCG_ADDR_GATE), ~DSCG_RW_MASK);
		rdc(32'(DSCG_ADDR_GATE), 32'h0);
		rdc(32'h0000_0200, 32'h0);
		run_clock_gate_1 <= 32'hFFFF_FFFF;
		light_sleep_clock_gate_1 <= 32'h0000_0011;
		auto_clock_gating_select <= 1'h0;
		st();
		`CHK(gv, 12'hFFF)
		auto_clock_gating_select <= 1'h1;
		deep_sleep_mode <= 1'h0;
		sleep_mode <= 1'h1;
		st();
		`CHK(gv, 12'h005)
		rdc(32'(DSCG_ADDR_ACTIVE), 32'h0000_0011);
		deep_sleep_mode <= 1'h1;
		st();
		`CHK(gv, 12'h000)
		auto_clock_gating_select <= 1'h0;
		st();
		`CHK(gv, 12'hFFF)
		`CHK(hresp, DSCG_HRESP_OKAY)
		`CHK(hreadyout, 1'h1)
		stop_test();
	end
endmodule
bind dscg_gate_bank dscg_gate_bank_chk i_dscg_gate_bank_chk (.*);
`default_nettype wire
